// File: hw/zbt_array.sv
// Storage array with per-lane write and registered read data.
// Assumes the caller merges a same-edge write into the read data itself.
`timescale 1ns/100ps
module zbt_array
  import zbt_pkg::*;
(
  // Clock
  input wire logic clk,
  // Access port
  zbt_mem_if.mem port
);
  logic [DATA_W-1:0] store [DEPTH];
  logic [DATA_W-1:0] rdata_q;

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (port.wr && port.lane_we[i])
      begin
        store[port.addr][i*LANE_W +: LANE_W] <= port.wdata[i*LANE_W +: LANE_W];
      end
    end
    if (port.rd)
    begin
      rdata_q <= store[port.raddr];
    end
  end

  assign port.rdata = rdata_q;
endmodule

// File: hw/zbt_burst_addr.sv
// Burst address generator: loads an address, steps the two low bits.
// Assumes load and advance are already qualified by clock gate and sleep.
`timescale 1ns/100ps
module zbt_burst_addr
  import zbt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic load,
  input wire logic advance,
  input wire logic interleave,
  input wire logic [ADDR_W-1:0] ext_addr,
  // Result
  output logic [ADDR_W-1:0] addr
);
  logic [ADDR_W-1:0] base_q, base_d;
  logic [1:0] cnt_q, cnt_d;

  always_comb
  begin
    base_d = base_q;
    cnt_d = cnt_q;
    if (load)
    begin
      base_d = ext_addr;
      cnt_d = BURST_ZERO;
    end
    else if (advance)
    begin
      cnt_d = 2'(cnt_q + BURST_STEP);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      base_q <= ADDR_ZERO;
      cnt_q <= BURST_ZERO;
    end
    else
    begin
      base_q <= base_d;
      cnt_q <= cnt_d;
    end
  end

  // Addresses for the current cycle, loaded or stepped
  always_comb
  begin
    if (load)
    begin
      addr = ext_addr;
    end
    else
    begin
      addr = {base_q[ADDR_W-1:2], burst_bits(base_q[1:0], cnt_d, interleave)};
    end
  end
endmodule

// File: hw/zbt_sram_port.sv
// Zero-turnaround pipelined synchronous SRAM: command decode and data bus.
// Assumes a memory controller drives all inputs on rising clk edges.
//
// How it works
// - Continuation cycles use advance high; selects and read/write ignored then.
// - Burst direction fixed by read/write level at address load.
// - Continue-deselect after deselect: bus stays off, no array access.
// - Dummy read with output drive disabled leaves bus off, no-op.
// - Write with all lanes disabled changes nothing, bus stays off.
// - Output drivers off during writes regardless of output enable.
// - Clock gate high makes the edge ignored; all state holds except output enable, which clears with output drive disabled.
// - Stalled read keeps driving the held data while output drive stays enabled.
// - Stalled write holds the bus drive of the last edge (off with output drive disabled) and writes nothing.
// - Writes use low lane enables; reads ignore lane enables.
// - Lane enables a to d gate data lanes a to d.
// - Burst counter advances on every continuation cycle of a read or write burst, not after a deselect.
// - Linear order steps low two bits modulo four.
// - Interleaved order XORs loaded low bits with access count.
// - All lanes low gives a full-width write; any subset allowed.
// - Read/write sampled only with advance low.
// - Sleep request overrides all inputs at the next rising clk edge, array kept.
`timescale 1ns/100ps
module zbt_sram_port
  import zbt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Selects and commands
  input wire logic chip_select_n,
  input wire logic depth_select_pair,
  input wire logic depth_select_n,
  input wire logic advance_or_load,
  input wire logic read_write_n,
  input wire logic clock_gate_n,
  input wire logic output_drive_n,
  input wire logic sleep_request,
  input wire logic burst_order,
  // Address and lanes
  input wire logic [ADDR_W-1:0] address,
  input wire logic byte_lane_a_write_n,
  input wire logic byte_lane_b_write_n,
  input wire logic byte_lane_c_write_n,
  input wire logic byte_lane_d_write_n,
  // Data bus, split three ways
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe
);
  zbt_mem_if mem ();

  logic [LANES-1:0] lane_n;
  logic edge_ok;
  logic selected;
  logic load;
  logic cont;
  logic [ADDR_W-1:0] cur_addr;

  // Command pipeline: stage 1 and stage 2
  cyc_t dir_q, dir_d;
  cyc_t s1_q, s1_d;
  cyc_t s2_q, s2_d;
  logic [ADDR_W-1:0] a1_q, a1_d;
  logic [ADDR_W-1:0] a2_q, a2_d;
  logic oe_q, oe_d;
  logic [DATA_W-1:0] dout_q, dout_d;
  logic rd_pend_q, rd_pend_d;
  // Write that hit the read address on the read's array edge
  logic [LANES-1:0] fwd_q, fwd_d;
  logic [DATA_W-1:0] fwd_data_q, fwd_data_d;

  assign lane_n = {byte_lane_d_write_n, byte_lane_c_write_n, byte_lane_b_write_n, byte_lane_a_write_n};

  assign edge_ok = !clock_gate_n && !sleep_request;
  assign selected = !chip_select_n && !depth_select_n && depth_select_pair;
  assign load = edge_ok && !advance_or_load && selected;
  assign cont = edge_ok && advance_or_load;

  zbt_burst_addr u_addr (
    .clk(clk),
    .reset(reset),
    .load(load),
    .advance(cont && dir_q != CYC_IDLE),
    .interleave(burst_order),
    .ext_addr(address),
    .addr(cur_addr)
  );

  zbt_array u_array (
    .clk(clk),
    .port(mem.mem)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb
  begin
    dir_d = dir_q;
    s1_d = s1_q;
    s2_d = s2_q;
    a1_d = a1_q;
    a2_d = a2_q;
    if (edge_ok)
    begin
      if (!advance_or_load)
      begin
        dir_d = !selected ? CYC_IDLE : (read_write_n ? CYC_READ : CYC_WRITE);
      end
      s1_d = advance_or_load ? dir_q : dir_d;
      a1_d = cur_addr;
      s2_d = s1_q;
      a2_d = a1_q;
    end
  end

  // ----------------------------------------------------------------
  // Array access and data bus
  // ----------------------------------------------------------------
  always_comb
  begin
    mem.raddr = a1_q;
    mem.rd = edge_ok && s1_q == CYC_READ;
    // write data taken two edges after address
    // no write on a stalled edge
    // read ignores lanes, write uses low lanes
    mem.wr = edge_ok && s2_q == CYC_WRITE && lane_n != LANES_OFF;
    mem.addr = a2_q;
    mem.lane_we = ~lane_n;
    mem.wdata = data_in;
    rd_pend_d = rd_pend_q;
    dout_d = dout_q;
    oe_d = oe_q;
    fwd_d = fwd_q;
    fwd_data_d = fwd_data_q;
    if (sleep_request)
    begin
      oe_d = 1'b0;
      rd_pend_d = 1'b0;
    end
    else if (edge_ok)
    begin
      rd_pend_d = mem.rd;
      // Read and write share an edge: keep the new lanes
      fwd_d = (mem.wr && a2_q == a1_q) ? mem.lane_we : '0;
      fwd_data_d = data_in;
      // read data two edges after address
      oe_d = (s2_q == CYC_READ) && !output_drive_n;
      if (s2_q == CYC_READ)
      begin
        dout_d = mem.rdata;
        for (int i = 0; i < LANES; i++)
        begin
          if (fwd_q[i])
          begin
            dout_d[i*LANE_W +: LANE_W] = fwd_data_q[i*LANE_W +: LANE_W];
          end
        end
      end
    end
    else
    begin
      oe_d = oe_q && !output_drive_n;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dir_q <= CYC_IDLE;
      s1_q <= CYC_IDLE;
      s2_q <= CYC_IDLE;
      a1_q <= ADDR_ZERO;
      a2_q <= ADDR_ZERO;
      oe_q <= 1'b0;
      dout_q <= DATA_ZERO;
      rd_pend_q <= 1'b0;
      fwd_q <= '0;
      fwd_data_q <= DATA_ZERO;
    end
    else
    begin
      dir_q <= dir_d;
      s1_q <= s1_d;
      s2_q <= s2_d;
      a1_q <= a1_d;
      a2_q <= a2_d;
      oe_q <= oe_d;
      dout_q <= dout_d;
      rd_pend_q <= rd_pend_d;
      fwd_q <= fwd_d;
      fwd_data_q <= fwd_data_d;
    end
  end

  assign data_out = dout_q;
  assign data_oe = oe_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_STALL_HOLD: assert property (@(posedge clk) disable iff (reset)
    clock_gate_n |=> (s1_q == $past(s1_q) && a1_q == $past(a1_q)))
    else $error("stalled edge changed pipeline");
  AST_WRITE_NO_DRIVE: assert property (@(posedge clk) disable iff (reset)
    (edge_ok && s2_q == CYC_WRITE) |=> !data_oe)
    else $error("bus driven in write");
  AST_READ_LATENCY: assert property (@(posedge clk) disable iff (reset)
    (load && read_write_n && !output_drive_n ##1 edge_ok && !output_drive_n && !sleep_request
     ##1 edge_ok && !output_drive_n && !sleep_request) |=> data_oe)
    else $error("read data not on bus two edges after address");
  AST_DUMMY_READ: assert property (@(posedge clk) disable iff (reset)
    (edge_ok && output_drive_n) |=> !data_oe)
    else $error("dummy read drove bus");
  AST_ABORT: assert property (@(posedge clk) disable iff (reset)
    (s2_q == CYC_WRITE && lane_n == LANES_OFF) |-> !mem.wr)
    else $error("write abort wrote array");
  AST_STALL_NO_WRITE: assert property (@(posedge clk) disable iff (reset)
    clock_gate_n |-> !mem.wr)
    else $error("write on stalled edge");
  AST_STALL_READ_HOLD: assert property (@(posedge clk) disable iff (reset)
    (data_oe && clock_gate_n && !output_drive_n && !sleep_request) |=> (data_oe && $stable(data_out)))
    else $error("stalled read dropped bus");
  AST_DESELECT: assert property (@(posedge clk) disable iff (reset)
    (edge_ok && !advance_or_load && !selected) |=> s1_q == CYC_IDLE ##1 (s2_q == CYC_IDLE || !$past(edge_ok)))
    else $error("deselect started a cycle");
  AST_SLEEP_OFF: assert property (@(posedge clk) disable iff (reset)
    sleep_request |=> !data_oe)
    else $error("bus driven in sleep");
endmodule

// File: inc/zbt_mem_if.sv
// Array access port between the command pipeline and the memory.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
interface zbt_mem_if;
  import zbt_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic wr;
  logic [LANES-1:0] lane_we;
  logic [DATA_W-1:0] wdata;
  logic rd;
  logic [ADDR_W-1:0] raddr;
  logic [DATA_W-1:0] rdata;
  modport ctrl (output addr, wr, lane_we, wdata, rd, raddr, input rdata);
  modport mem (input addr, wr, lane_we, wdata, rd, raddr, output rdata);
endinterface

// File: inc/zbt_pkg.sv
// Constants, types and commands of the zero-turnaround SRAM port.
// Assumes a single 50 MHz clock and a synchronous active-high reset.
package zbt_pkg;
  localparam int ADDR_W = 17;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [1:0] BURST_STEP = 2'h1;
  localparam logic [1:0] BURST_ZERO = 2'h0;
  localparam logic [LANES-1:0] LANES_OFF = 4'hF;
  localparam logic [DATA_W-1:0] DATA_ZERO = 36'h0;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 17'h0;

  typedef enum logic [1:0] {
    CYC_IDLE = 2'h0,
    CYC_READ = 2'h1,
    CYC_WRITE = 2'h3
  } cyc_t;

  // Low address bits of a burst access
  function automatic logic [1:0] burst_bits(input logic [1:0] base, input logic [1:0] cnt,
                                            input logic interleave);
    burst_bits = interleave ? (base ^ cnt) : 2'(base + cnt);
  endfunction
endpackage

// File: verification/ctl_model.sv
// Controller model that drives every command, address and data input of the port.
// Assumes the bench calls step once per cycle, just after the rising clock edge.
`timescale 1ns/100ps
module ctl_model
  import zbt_pkg::*;
(
  // Selects and commands
  output logic chip_select_n,
  output logic depth_select_pair,
  output logic depth_select_n,
  output logic advance_or_load,
  output logic read_write_n,
  output logic clock_gate_n,
  output logic output_drive_n,
  output logic sleep_request,
  output logic burst_order,
  // Address, lanes and write data
  output logic [ADDR_W-1:0] address,
  output logic [LANES-1:0] lanes_n,
  output logic [DATA_W-1:0] data_in
);
  logic order_level = 1'b0;
  assign burst_order = order_level;

  // ----------------------------------------
  // Cycle driver
  // ----------------------------------------
  initial
  begin
    {chip_select_n, depth_select_pair, depth_select_n} = 3'h4;
    {clock_gate_n, sleep_request, advance_or_load, read_write_n, output_drive_n} = 5'h0;
    address = ADDR_ZERO;
    lanes_n = LANES_OFF;
    data_in = DATA_ZERO;
  end

  task automatic step(input logic [7:0] ctl, input logic [ADDR_W-1:0] ad, input logic [LANES-1:0] ln,
                      input logic [DATA_W-1:0] d);
    {clock_gate_n, sleep_request, advance_or_load, read_write_n} = ctl[7:4];
    {chip_select_n, depth_select_pair, depth_select_n, output_drive_n} = ctl[3:0];
    address = ad;
    lanes_n = ln;
    data_in = d;
  endtask
endmodule

// File: verification/tb_top.sv
// Self-checking bench: random command mix compared with a queue-based model.
// Assumes the port is alone on its bus and the array starts unknown.
`timescale 1ns/100ps
module tb_top;
  import zbt_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cs_n, sel_p, sel_n, adv, rw, gate_n, oe_n, sleep, order, data_oe, eo;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0] ln_n;
  logic [DATA_W-1:0] wdata, data_out, ed;
  logic [DATA_W-1:0] mem [int];
  logic [31:0] rnd = 32'h2E;
  logic [7:0] c;
  int pk[$], pa[$];
  int miscompares = 0, n_compared = 0, act = 0, dir = 0, base = 0, cnt = 0;

  initial
  begin
    forever #10 clk = ~clk;
  end

  ctl_model i_ctl_model (.chip_select_n(cs_n), .depth_select_pair(sel_p), .depth_select_n(sel_n),
    .advance_or_load(adv), .read_write_n(rw), .clock_gate_n(gate_n), .output_drive_n(oe_n),
    .sleep_request(sleep), .burst_order(order), .address(addr), .lanes_n(ln_n), .data_in(wdata));
  zbt_sram_port i_zbt_sram_port (.clk(clk), .reset(reset), .chip_select_n(cs_n), .depth_select_pair(sel_p),
    .depth_select_n(sel_n), .advance_or_load(adv), .read_write_n(rw), .clock_gate_n(gate_n),
    .output_drive_n(oe_n), .sleep_request(sleep), .burst_order(order), .address(addr),
    .byte_lane_a_write_n(ln_n[0]), .byte_lane_b_write_n(ln_n[1]), .byte_lane_c_write_n(ln_n[2]),
    .byte_lane_d_write_n(ln_n[3]), .data_in(wdata), .data_out(data_out), .data_oe(data_oe));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One cycle: check last edge, drive, predict the coming edge
  task automatic run(input logic [7:0] ctl, input int ad, input logic [LANES-1:0] ln);
    logic [DATA_W-1:0] d;
    int nk;
    int na;
    @(posedge clk);
    #1;
    check({35'h0, data_oe}, {35'h0, eo});
    if (eo === 1'b1) check(data_out, ed);
    rnd = lfsr(rnd);
    d = {rnd[3:0], rnd};
    i_ctl_model.step(ctl, ad, ln, d);
    if (ctl[6]) eo = 1'b0;
    else if (!ctl[7])
    begin
      if (pk[0] == 2) for (int i = 0; i < LANES; i++) if (!ln[i]) mem[pa[0]][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
      eo = (pk[0] == 1) && !ctl[0];
      if (pk[0] == 1) ed = mem[pa[0]];
      nk = 0;
      na = 0;
      if (!ctl[5] && ctl[3:1] == 3'h2)
      begin
        act = 1;
        dir = ctl[4] ? 1 : 2;
        base = ad;
        cnt = 0;
      end
      else if (!ctl[5]) act = 0;
      else cnt = cnt + 1;
      if (act) na = (base & ~3) | (order ? ((base ^ cnt) & 3) : ((base + cnt) & 3));
      if (act) nk = dir;
      pk = {pk[1], nk};
      pa = {pa[1], na};
    end
    // stalled read drops only with drive disabled
    else eo = eo && !ctl[0];
  endtask

  task automatic do_reset(input logic bo);
    reset = 1'b1;
    i_ctl_model.order_level = bo;
    pk = {0, 0};
    pa = {0, 0};
    act = 0;
    eo = 1'b0;
    repeat (16) run(8'h08, 0, LANES_OFF);
    reset = 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    #1000000;
    miscompares++;
    complete_run();
  end

  initial
  begin
    do_reset(1'b0);
    for (int b = 0; b < 64; b += 4)
    begin
      run(8'h04, 'h1A5C0 + b, 4'h0);
      repeat (3) run(8'h24, 0, 4'h0);
    end
    repeat (2) run(8'h08, 0, 4'h0);
    for (int p = 0; p < 2; p++)
    begin
      if (p == 1) do_reset(1'b1);
      repeat (1500)
      begin
        rnd = lfsr(rnd);
        c = rnd[7:0] & 8'h3F;
        c[7] = (rnd[10:8] == 3'h0);
        c[0] = (rnd[12:11] == 2'h0) && !c[7];
        if (rnd[15:13] != 3'h0) c[3:1] = 3'h2;
        run(c, 'h1A5C0 + rnd[21:16], rnd[25:22]);
      end
      repeat (2) run(8'h08, 0, 4'h0);
      repeat (4) run(8'h54, 'h1A5C0, 4'h0);
      run(8'h14, 'h1A5C6, LANES_OFF);
      repeat (3) run(8'h34, 0, LANES_OFF);
      repeat (3) run(8'h08, 0, LANES_OFF);
    end
    complete_run();
  end
endmodule
